// file: dec_channel.sv
module dec_channel
  import dec_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             level_i,
  input  wire logic             pos_sel_i,
  input  wire logic             preset_i,
  input  wire logic [CNT_W-1:0] preset_val_i,
  input  wire logic             clear_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  evt_o,
  output logic                  ovf_o
);

  logic             prev_r;
  logic [CNT_W-1:0] cnt_r;
  logic             evt_r;
  logic             ovf_r;
  logic             rise;
  logic             fall;
  logic             hit;

  assign rise = level_i & ~prev_r;
  assign fall = ~level_i & prev_r;
  assign hit  = pos_sel_i ? rise : fall;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_i;
    end
  end

  // An edge in the same cycle as preset or clear is kept, not lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (preset_i) begin
      cnt_r <= preset_val_i + CNT_W'(hit);
    end else if (clear_i) begin
      cnt_r <= CNT_W'(hit);
    end else if (hit) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      evt_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      evt_r <= hit;
      ovf_r <= hit && !preset_i && !clear_i && (cnt_r == 32'hFFFF_FFFF);
    end
  end

  assign count_o = cnt_r;
  assign evt_o   = evt_r;
  assign ovf_o   = ovf_r;

endmodule

// file: dec_debounce.sv
module dec_debounce
  import dec_pkg::*;
#(
  parameter int N = CH_NUM
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic [N-1:0]         raw_i,
  input  wire logic [DEB_CNT_W-1:0] lim_i,
  output logic      [N-1:0]         level_o
);

  // Shared limit: one setting for every channel
  for (genvar g = 0; g < N; g++) begin : g_ch
    logic [DEB_CNT_W-1:0] cnt_r;
    logic                 lvl_r;

    // New level only after it held steady for the whole reject interval
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        cnt_r <= '0;
        lvl_r <= 1'b0;
      end else if (raw_i[g] != lvl_r) begin
        if (cnt_r >= lim_i - DEB_CNT_W'(1)) begin
          lvl_r <= raw_i[g];
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r + DEB_CNT_W'(1);
        end
      end else begin
        // Any bounce back restarts the wait
        cnt_r <= '0;
      end
    end

    assign level_o[g] = lvl_r;
  end

endmodule

// file: dec_edge_counter.sv
// Operation
// - Filter rejects pulses shorter than 20, 2 or 0.2 ms per setting.
// - Pulses between reject time and 50, 5 or 1 ms may be missed.
// - Edges count only when both phases reach the reject time.
// - Interrupt delay is internal response plus debounce response time.
// - Enabled interrupts fire on programmed edges or counter rollover to zero.
// - One signed 32-bit counter per channel, sixteen in the wide variant.
// - Countable frequency is 10, 100 or 500 Hz by setting.
// - Detect rising and falling edges; act on the programmed one.
// - Narrow variant delivers enabled interrupts within 50 ms.
// - Narrow variant has eight counters; phases must last 50 ms.
// - One debounce setting shared by all channels.
// - Counter wraps max to min; counter interrupt only on -1 to 0.
// - Host reads, or reads and clears, one count without touching others.
// - Separate event and counter interrupt enables per channel.
module dec_edge_counter
  import dec_pkg::*;
#(
  parameter int N_CH         = CH_NUM,
  parameter int REJ_SLOW_CYC_P = REJ_SLOW_CYC,
  parameter int REJ_MID_CYC_P  = REJ_MID_CYC,
  parameter int REJ_FAST_CYC_P = REJ_FAST_CYC
) (
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic [N_CH-1:0] din_i,
  input  wire logic [7:0]      avs_address_i,
  input  wire logic            avs_read_i,
  input  wire logic            avs_write_i,
  input  wire logic [31:0]     avs_writedata_i,
  input  wire logic [3:0]      avs_byteenable_i,
  output logic      [31:0]     avs_readdata_o,
  output logic                 avs_waitrequest_o,
  output logic                 irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address lies in a per-channel window and names an existing channel
  function automatic logic win_hit(input logic [7:0] a, input logic [1:0] win);
    return (a[7:6] == win) && (32'(a[5:2]) < N_CH);
  endfunction

  // Reject limit for a setting; an unused code falls back to the slowest
  function automatic logic [DEB_CNT_W-1:0] deb_lim(input logic [1:0] sel);
    logic [DEB_CNT_W-1:0] l;
    l = DEB_CNT_W'(REJ_SLOW_CYC_P);
    unique case (sel)
      DEB_MID:  l = DEB_CNT_W'(REJ_MID_CYC_P);
      DEB_FAST: l = DEB_CNT_W'(REJ_FAST_CYC_P);
      default:  l = DEB_CNT_W'(REJ_SLOW_CYC_P);
    endcase
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  dec_bus_t               bus_st_r;
  logic                   wait_r;
  logic [31:0]            rdata_r;
  logic [31:0]            rd_nxt;
  logic                   irq_r;
  logic [1:0]             deb_sel_r;
  logic [DEB_CNT_W-1:0]   lim_r;
  logic [N_CH-1:0]        edge_pos_r;
  logic [N_CH-1:0]        evt_ie_r;
  logic [N_CH-1:0]        cnt_ie_r;
  logic [N_CH-1:0]        evt_st_r;
  logic [N_CH-1:0]        cnt_st_r;
  logic [N_CH-1:0]        level;
  logic [N_CH-1:0]        evt_p;
  logic [N_CH-1:0]        ovf_p;
  logic [N_CH-1:0]        preset_v;
  logic [N_CH-1:0]        clear_v;
  logic [N_CH-1:0]        pend;
  logic [CNT_W-1:0]       cnt_w [N_CH];
  logic                   take;
  logic                   wr_take;
  logic                   rd_take;
  logic [3:0]             ch;
  logic [31:0]            wmask;
  logic [31:0]            wdm;
  logic [CNT_W-1:0]       preset_val;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, answer on the second edge

  assign take    = (avs_read_i || avs_write_i) && (bus_st_r == BUS_IDLE);
  assign wr_take = take && avs_write_i;
  assign rd_take = take && avs_read_i;
  assign ch      = avs_address_i[5:2];
  assign wmask   = be_expand(avs_byteenable_i);
  assign wdm     = avs_writedata_i & wmask;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_st_r <= BUS_IDLE;
      wait_r   <= 1'b1;
    end else begin
      unique case (bus_st_r)
        BUS_IDLE: begin
          if (take) begin
            bus_st_r <= BUS_ACK;
            wait_r   <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_st_r <= BUS_IDLE;
          wait_r   <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (win_hit(avs_address_i, WIN_COUNT) || win_hit(avs_address_i, WIN_CLEAR)) begin
      rd_nxt = cnt_w[ch];
    end else begin
      unique case ({avs_address_i[7:2], 2'b00})
        OFS_CTRL:     rd_nxt[CTRL_DEB_LSB +: 2] = deb_sel_r;
        OFS_STATE:    rd_nxt[N_CH-1:0] = level;
        OFS_EDGE_POS: rd_nxt[N_CH-1:0] = edge_pos_r;
        OFS_EVT_IE:   rd_nxt[N_CH-1:0] = evt_ie_r;
        OFS_CNT_IE:   rd_nxt[N_CH-1:0] = cnt_ie_r;
        OFS_EVT_STAT: rd_nxt[N_CH-1:0] = evt_st_r;
        OFS_CNT_STAT: rd_nxt[N_CH-1:0] = cnt_st_r;
        OFS_IRQ_PEND: rd_nxt[N_CH-1:0] = pend;
        default:      rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Snapshot taken on the same edge as a read-and-clear, so no count slips
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      deb_sel_r <= CTRL_DEB_RST;
    end else if (wr_take && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
      deb_sel_r <= avs_writedata_i[CTRL_DEB_LSB +: 2];
    end
  end

  // Registered so the long compare in the filters stays off the bus path
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lim_r <= DEB_CNT_W'(REJ_SLOW_CYC_P);
    end else begin
      lim_r <= deb_lim(deb_sel_r);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      edge_pos_r <= EDGE_POS_RST[N_CH-1:0];
    end else if (wr_take && avs_address_i == OFS_EDGE_POS) begin
      edge_pos_r <= (edge_pos_r & ~wmask[N_CH-1:0]) | wdm[N_CH-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      evt_ie_r <= IE_RST[N_CH-1:0];
      cnt_ie_r <= IE_RST[N_CH-1:0];
    end else if (wr_take && avs_address_i == OFS_EVT_IE) begin
      evt_ie_r <= (evt_ie_r & ~wmask[N_CH-1:0]) | wdm[N_CH-1:0];
    end else if (wr_take && avs_address_i == OFS_CNT_IE) begin
      cnt_ie_r <= (cnt_ie_r & ~wmask[N_CH-1:0]) | wdm[N_CH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounce filters, shared setting

  dec_debounce #(
    .N (N_CH)
  ) u_deb (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .raw_i     (din_i),
    .lim_i     (lim_r),
    .level_o   (level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel counters

  assign preset_val = (cnt_w[ch] & ~wmask) | wdm;

  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    assign preset_v[g] = wr_take && win_hit(avs_address_i, WIN_COUNT) && (32'(ch) == g);
    assign clear_v[g]  = rd_take && win_hit(avs_address_i, WIN_CLEAR) && (32'(ch) == g);

    dec_channel u_ch (
      .clk_sys_i    (clk_sys_i),
      .rst_i        (rst_i),
      .level_i      (level[g]),
      .pos_sel_i    (edge_pos_r[g]),
      .preset_i     (preset_v[g]),
      .preset_val_i (preset_val),
      .clear_i      (clear_v[g]),
      .count_o      (cnt_w[g]),
      .evt_o        (evt_p[g]),
      .ovf_o        (ovf_p[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; a new event wins over the clear

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      evt_st_r <= '0;
    end else begin
      evt_st_r <= (evt_st_r & ~((wr_take && avs_address_i == OFS_EVT_STAT) ?
                  wdm[N_CH-1:0] : '0)) | evt_p;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_st_r <= '0;
    end else begin
      cnt_st_r <= (cnt_st_r & ~((wr_take && avs_address_i == OFS_CNT_STAT) ?
                  wdm[N_CH-1:0] : '0)) | ovf_p;
    end
  end

  assign pend = (evt_st_r & evt_ie_r) | (cnt_st_r & cnt_ie_r);

  // Delay is reject time plus three cycles, far inside the response budget
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign irq_o             = irq_r;

endmodule

// file: dec_edge_counter_monitor.sv
module dec_edge_counter_monitor
  import dec_pkg::*;
#(
  parameter int N_CH           = CH_NUM,
  parameter int REJ_SLOW_CYC_P = REJ_SLOW_CYC,
  parameter int REJ_MID_CYC_P  = REJ_MID_CYC,
  parameter int REJ_FAST_CYC_P = REJ_FAST_CYC
) (
  input wire logic            clk_sys_i,
  input wire logic            rst_i,
  input wire logic [N_CH-1:0] din_i,
  input wire logic            avs_read_i,
  input wire logic            avs_write_i,
  input wire logic [31:0]     avs_readdata_o,
  input wire logic            avs_waitrequest_o,
  input wire logic            irq_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [N_CH-1:0] din_q_r;
  int              quiet_r;
  int              wq_r;

  // Saturating ages of the last input change and the last write
  always_ff @(posedge clk_sys_i) begin
    din_q_r <= din_i;
    if (rst_i || din_i != din_q_r) quiet_r <= 0;
    else if (quiet_r < 32'h4000_0000) quiet_r <= quiet_r + 1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || avs_write_i) wq_r <= 0;
    else if (wq_r < 32'h4000_0000) wq_r <= wq_r + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered in the next cycle");
  a_ack_single: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_ack_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without a request");
  a_idle_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low with no request");
  a_rdata_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$stable(avs_readdata_o) |-> !avs_waitrequest_o && $past(avs_read_i))
    else $error("read data changed outside a read answer");
  a_irq_fall: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(irq_o) |-> wq_r < 4)
    else $error("interrupt dropped without a write");
  a_reject_short: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(irq_o) |-> (quiet_r >= REJ_FAST_CYC_P - 2 || wq_r < 5))
    else $error("interrupt raised by a pulse shorter than reject time");
  a_irq_calm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (quiet_r > REJ_SLOW_CYC_P + 8 && wq_r > 5) |-> $stable(irq_o))
    else $error("interrupt moved with quiet inputs and no write");
endmodule

bind dec_edge_counter dec_edge_counter_monitor #(
  .N_CH(N_CH), .REJ_SLOW_CYC_P(REJ_SLOW_CYC_P),
  .REJ_MID_CYC_P(REJ_MID_CYC_P), .REJ_FAST_CYC_P(REJ_FAST_CYC_P)
) u_mon (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .din_i(din_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o)
);

// file: dec_edge_counter_tb_top.sv
module dec_edge_counter_tb_top
  import dec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Short reject counts keep the run brief
  localparam int LS = 40;
  localparam int LM = 20;
  localparam int LF = 8;

  logic              clk_sys_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic              rd        = 1'b0;
  logic              wr        = 1'b0;
  logic [7:0]        adr       = 8'h00;
  logic [31:0]       wd        = 32'h0;
  logic [CH_NUM-1:0] din;
  logic [31:0]       rdata;
  logic [31:0]       q;
  logic              wait_o;
  logic              irq;
  int                n_fail      = 0;
  int                check_count = 0;
  int                cyc         = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  dec_edge_counter #(.N_CH(CH_NUM), .REJ_SLOW_CYC_P(LS), .REJ_MID_CYC_P(LM),
    .REJ_FAST_CYC_P(LF)) DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .din_i(din), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .irq_o(irq)
  );

  dec_field_model #(.N(CH_NUM)) F (.clk_sys_i(clk_sys_i), .din_o(din));

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks=%0d errors=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  // No local limit: only the cycle ceiling may end a stuck wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk_sys_i);
    end while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_EDGE_POS, {16'h0, EDGE_POS_RST});
    rdchk(OFS_EVT_IE, 32'h0);
    rdchk(OFS_CNT_IE, 32'h0);
    rdchk(OFS_CNT_STAT, 32'h0);
    bus(1'b1, 8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0);
    bus(1'b1, OFS_STATE, 32'hFFFF_FFFF);
    rdchk(OFS_STATE, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  // One setting for all channels; short pulses vanish, long ones count once
  task automatic t_debounce();
    int lim;
    for (int s = 0; s < 3; s++) begin
      lim = (s == 0) ? LS : (s == 1) ? LM : LF;
      bus(1'b1, OFS_CTRL, s);
      rdchk(OFS_CTRL, s);
      // A level stands hold+1 edges, so this pulse is one cycle short
      F.set(3, 1'b1, lim - 2);
      F.set(3, 1'b0, lim + 6);
      F.set(3, 1'b1, lim + 6);
      F.set(11, 1'b1, lim + 6);
      F.set(3, 1'b0, lim + 6);
      F.set(11, 1'b0, lim + 6);
      rdchk(8'h8C, 32'h1);
      rdchk(8'h8C, 32'h0);
      rdchk(8'hAC, 32'h1);
      rdchk(8'h48, 32'h0);
    end
  endtask

  task automatic t_falling();
    bus(1'b1, OFS_EDGE_POS, 32'h0000_FFF7);
    F.set(3, 1'b1, LF + 6);
    rdchk(OFS_STATE, 32'h8);
    rdchk(8'h4C, 32'h0);
    F.set(3, 1'b0, LF + 6);
    rdchk(8'h8C, 32'h1);
    bus(1'b1, OFS_EDGE_POS, 32'h0000_FFFF);
  endtask

  task automatic t_irq();
    rdchk(OFS_EVT_STAT, 32'h0000_0808);
    bus(1'b1, OFS_EVT_STAT, 32'hFFFF_FFFF);
    rdchk(OFS_EVT_STAT, 32'h0);
    bus(1'b1, 8'h54, 32'hFFFF_FFFF);
    rdchk(OFS_CNT_STAT, 32'h0);
    bus(1'b1, OFS_CNT_IE, 32'h20);
    F.set(5, 1'b1, LF + 6);
    rdchk(8'h54, 32'h0);
    rdchk(OFS_CNT_STAT, 32'h20);
    rdchk(OFS_EVT_STAT, 32'h20);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_CNT_STAT, 32'h20);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_EVT_IE, 32'h20);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_EVT_STAT, 32'h20);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h54, 32'h7FFF_FFFF);
    F.set(5, 1'b0, LF + 6);
    F.set(5, 1'b1, LF + 6);
    rdchk(8'h54, 32'h8000_0000);
    rdchk(OFS_CNT_STAT, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdchk(OFS_IRQ_PEND, 32'h20);
    bus(1'b1, OFS_EVT_STAT, 32'h20);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_debounce();
    t_falling();
    t_irq();
    results();
  end
endmodule

// file: dec_field_model.sv
module dec_field_model
  import dec_pkg::*;
#(
  parameter int N = CH_NUM
) (
  input  wire logic         clk_sys_i,
  output logic      [N-1:0] din_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial din_o = '0;

  // Level changes only after an edge; each value then stands for hold+1 sampled edges
  task automatic set(input int ch, input logic v, input int hold);
    @(posedge clk_sys_i);
    din_o[ch] <= v;
    repeat (hold) @(posedge clk_sys_i);
  endtask
endmodule

// file: dec_pkg.sv
package dec_pkg;

  // Channel count of the wide variant; the narrow variant uses 8
  localparam int CH_NUM      = 16;
  localparam int CH_NUM_NARROW = 8;
  localparam int CNT_W       = 32;
  localparam int DEB_CNT_W   = 20;

  // Sampling clock and bounce-reject times per debounce setting
  localparam int  CLK_HZ      = 40_000_000;
  localparam real REJ_SLOW_MS = 20.0;
  localparam real REJ_MID_MS  = 2.0;
  localparam real REJ_FAST_MS = 0.2;
  localparam int  REJ_SLOW_CYC = int'($ceil(REJ_SLOW_MS * real'(CLK_HZ) / 1000.0));
  localparam int  REJ_MID_CYC  = int'($ceil(REJ_MID_MS * real'(CLK_HZ) / 1000.0));
  localparam int  REJ_FAST_CYC = int'($ceil(REJ_FAST_MS * real'(CLK_HZ) / 1000.0));

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATE    = 8'h04;
  localparam logic [7:0] OFS_EDGE_POS = 8'h08;
  localparam logic [7:0] OFS_EVT_IE   = 8'h0C;
  localparam logic [7:0] OFS_CNT_IE   = 8'h10;
  localparam logic [7:0] OFS_EVT_STAT = 8'h14;
  localparam logic [7:0] OFS_CNT_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h1C;
  localparam logic [1:0] WIN_COUNT    = 2'h1;
  localparam logic [1:0] WIN_CLEAR    = 2'h2;

  // Control field layout and reset values
  localparam int         CTRL_DEB_LSB   = 0;
  localparam logic [1:0] CTRL_DEB_RST   = 2'h0;
  localparam logic [CH_NUM-1:0] EDGE_POS_RST = 16'hFFFF;
  localparam logic [CH_NUM-1:0] IE_RST       = 16'h0000;

  typedef enum logic [1:0] {
    DEB_SLOW = 2'b00,
    DEB_MID  = 2'b01,
    DEB_FAST = 2'b10
  } dec_deb_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } dec_bus_t;

  function automatic logic [31:0] be_expand(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

endpackage
